// file: aebm_lane.sv
// aebm_lane: picks the next outgoing operand bytes and merges returned bytes
// assumes operand is left-justified, most significant byte first
`timescale 1ns/1ps
module aebm_lane (
    // operand state
    input wire logic [31:0] operand,
    input wire logic [2:0] done_bytes,
    // lane results
    output logic [15:0] out_word,
    output logic [31:0] merged8,
    output logic [31:0] merged16,
    // read data
    input wire logic [15:0] rd_data
);
    logic [31:0] shifted;
    // bytes already moved are shifted out of the top
    assign shifted = operand << {done_bytes, 3'b000};
    assign out_word = shifted[31:16];
    // an 8-bit port returns one byte on the upper lane, a 16-bit port two bytes
    assign merged8 = operand | ({rd_data[15:8], 24'h000000} >> {done_bytes, 3'b000});
    assign merged16 = operand | ({rd_data, 16'h0000} >> {done_bytes, 3'b000});
endmodule : aebm_lane

// file: aebm_master.sv
// aebm_master: asynchronous external bus master with dynamic port sizing
// assumes an internal requester holding its request until done pulses; slave inputs synchronous to CLK
`timescale 1ns/1ps
//
// Operation
// - 24 address outputs, 16 bidirectional data lines
// - size code byte 01, word 10, three 11, long 00
// - size shows remaining bytes, driven at start
// - direction changes only when it differs
// - three-bit space code valid with address strobe
// - address of most significant byte still moved
// - address strobe half clock after cycle start
// - read data captured at cycle's last falling edge
// - writes drive all sixteen data lines
// - write data half clock after address strobe
// - read data strobe together with address strobe
// - write data strobe one clock after address strobe
// - acknowledge decode: wait, 8-bit, 16-bit, reserved
// - bus fault terminates; with stall, bus error exception
// - auto vector only ends interrupt-acknowledge cycles
// - assume 16-bit port, repeat for narrower ports
// - long word two or four cycles
// - byte zero is most significant byte
// - long word upper word moves first
module aebm_master
    import aebm_pkg::*;
(
    // clock and reset
    input wire logic CLK,
    input wire logic SRST,
    // internal request
    input wire logic REQ_VALID,
    input wire logic REQ_READ,
    input wire logic [2:0] REQ_BYTES,
    input wire logic [aebm_pkg::ADDR_W-1:0] REQ_ADDR,
    input wire logic [2:0] REQ_SPACE,
    input wire logic REQ_IACK,
    input wire logic [31:0] REQ_WDATA,
    // internal answer
    output logic DONE,
    output logic [31:0] RDATA,
    output logic BUS_ERROR,
    output logic BUS_ERROR_EXC,
    output logic AUTO_VECTOR,
    // external bus outputs
    output logic [aebm_pkg::ADDR_W-1:0] ADDR,
    output logic TRANSFER_SIZE_HIGH,
    output logic TRANSFER_SIZE_LOW,
    output logic [2:0] SPACE_CODE,
    output logic READ_NOT_WRITE,
    output logic ADDRESS_STROBE_N,
    output logic DATA_STROBE_N,
    // data lines
    input wire logic [aebm_pkg::DATA_W-1:0] DATA_IN,
    output logic [aebm_pkg::DATA_W-1:0] DATA_OUT,
    output logic DATA_OE,
    // slave terminators
    input wire logic PORT_SIZE_ACK_HIGH_N,
    input wire logic PORT_SIZE_ACK_LOW_N,
    input wire logic BUS_FAULT_N,
    input wire logic STALL_LINE_N,
    input wire logic AUTO_VECTOR_TERM_N
);
    import aebm_pkg::*;

    // one CLK cycle stands for one bus half-clock phase
    aebm_state_e state_r, state_nxt;
    logic [31:0] operand_r;
    logic [2:0] total_r;
    logic [2:0] done_r;
    logic read_r;
    logic iack_r;
    logic [ADDR_W-1:0] base_r;
    logic [15:0] out_word;
    logic [31:0] merged8;
    logic [31:0] merged16;
    logic [2:0] remain;
    logic [1:0] size_code;
    logic [1:0] ack;
    logic ack_term, fault_term, auto_vector_term_term, any_term;
    logic [2:0] moved;
    logic [2:0] done_sum;
    logic finished;
    // decoded phases, lane selection and answers
    logic take;
    logic cycle_start;
    logic cycle_end;
    logic operand_end;
    logic take_read;
    logic odd_lane;
    logic lone_byte;
    logic oe_on;
    logic oe_off;
    logic ds_write;
    logic fault_exc;
    logic auto_vector_term_only;
    logic rnw_flip;
    logic [2:0] space_r;
    logic [15:0] rd_lane;
    logic [15:0] wr_word;
    logic [31:0] merged;
    logic [31:0] wdata_just;
    logic [31:0] rdata_just;
    logic [ADDR_W-1:0] next_addr;

    // byte steering for both directions
    aebm_lane u_lane (
        .operand(operand_r),
        .done_bytes(done_r),
        .out_word(out_word),
        .merged8(merged8),
        .merged16(merged16),
        .rd_data(rd_lane)
    );

    // remaining byte count becomes the size code; four maps to 00
    assign remain = total_r - done_r;
    assign size_code = (remain == BYTES_FOUR) ? SIZE_LONG : remain[1:0];

    // termination decode
    assign ack = {PORT_SIZE_ACK_HIGH_N, PORT_SIZE_ACK_LOW_N};
    assign ack_term = (ack == ACK_PORT8) || (ack == ACK_PORT16);
    assign fault_term = !BUS_FAULT_N;
    assign auto_vector_term_term = iack_r && !AUTO_VECTOR_TERM_N;
    assign any_term = ack_term || fault_term || auto_vector_term_term;

    // bytes moved: 16-bit port takes up to two, 8-bit port one
    assign moved = (ack == ACK_PORT16 && remain >= BYTES_TWO) ? BYTES_TWO : BYTES_ONE;
    assign done_sum = done_r + moved;
    assign finished = fault_term || auto_vector_term_term || (done_sum >= total_r);

    // cycle sequencer
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            AEBM_IDLE: if (REQ_VALID) state_nxt = AEBM_S0;
            AEBM_S0: state_nxt = AEBM_S1;
            AEBM_S1: state_nxt = AEBM_S2;
            AEBM_S2: state_nxt = AEBM_WAIT;
            AEBM_WAIT: if (any_term) state_nxt = AEBM_END;
            AEBM_END: state_nxt = AEBM_IDLE;
            default: state_nxt = AEBM_IDLE;
        endcase
    end

    // request capture and per-phase strobes of the sequencer
    assign take = (state_r == AEBM_IDLE) && REQ_VALID && (done_r == 3'h0);
    assign cycle_start = (state_r == AEBM_S0);
    assign cycle_end = (state_r == AEBM_WAIT) && any_term;
    assign operand_end = cycle_end && finished;
    assign take_read = cycle_end && read_r && ack_term;

    // a 16-bit port hands an odd single byte back on the lower lane
    assign odd_lane = (ack == ACK_PORT16) && ADDR[0] && (moved == BYTES_ONE);
    assign rd_lane = odd_lane ? {DATA_IN[7:0], DATA_IN[7:0]} : DATA_IN;
    assign merged = (moved == BYTES_TWO) ? merged16 : merged8;

    // a lone byte goes out on both lanes, so either port width finds it
    assign lone_byte = (remain == BYTES_ONE);
    assign wr_word = lone_byte ? {out_word[15:8], out_word[15:8]} : out_word;

    // justification between the right-aligned request and the left-aligned operand
    assign wdata_just = REQ_WDATA << {(BYTES_FOUR - REQ_BYTES), 3'b000};
    assign rdata_just = merged >> {(BYTES_FOUR - total_r), 3'b000};
    assign next_addr = base_r + {{(ADDR_W-3){1'b0}}, done_r};

    // data drive window and write data strobe
    assign oe_on = (state_r == AEBM_S1) && !read_r;
    assign oe_off = (state_r == AEBM_END);
    assign ds_write = (state_r == AEBM_S2) && !read_r;

    // answers and direction flip decoded once
    assign fault_exc = fault_term && !STALL_LINE_N;
    assign auto_vector_term_only = auto_vector_term_term && !fault_term;
    assign rnw_flip = cycle_start && (READ_NOT_WRITE != read_r);

    // sequencer state
    always_ff @(posedge CLK) begin
        if (SRST) begin
            state_r <= AEBM_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // request fields held for every bus cycle of one operand
    always_ff @(posedge CLK) begin
        if (SRST) begin
            total_r <= 3'h0;
            read_r <= 1'b0;
            iack_r <= 1'b0;
            base_r <= '0;
            space_r <= 3'h0;
        end else if (take) begin
            total_r <= REQ_BYTES;
            read_r <= REQ_READ;
            iack_r <= REQ_IACK;
            base_r <= REQ_ADDR;
            space_r <= REQ_SPACE;
        end
    end

    // operand store: loaded left-justified, filled by reads msb first
    always_ff @(posedge CLK) begin
        if (SRST) begin
            operand_r <= 32'h00000000;
        end else if (take) begin
            operand_r <= REQ_READ ? 32'h00000000 : wdata_just;
        end else if (take_read) begin
            operand_r <= merged;
        end
    end

    // bytes already moved; follow-on cycles carry the rest, upper word first
    always_ff @(posedge CLK) begin
        if (SRST) begin
            done_r <= 3'h0;
        end else if (cycle_end) begin
            done_r <= finished ? 3'h0 : done_sum;
        end
    end

    // address of the most significant byte still to move
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ADDR <= '0;
        end else if (cycle_start) begin
            ADDR <= next_addr;
        end
    end

    // remaining byte count on the size pins
    always_ff @(posedge CLK) begin
        if (SRST) begin
            TRANSFER_SIZE_HIGH <= 1'b0;
            TRANSFER_SIZE_LOW <= 1'b0;
        end else if (cycle_start) begin
            TRANSFER_SIZE_HIGH <= size_code[1];
            TRANSFER_SIZE_LOW <= size_code[0];
        end
    end

    // address space of the operand
    always_ff @(posedge CLK) begin
        if (SRST) begin
            SPACE_CODE <= 3'h0;
        end else if (cycle_start) begin
            SPACE_CODE <= space_r;
        end
    end

    // direction flips only at a cycle start that needs it
    always_ff @(posedge CLK) begin
        if (SRST) begin
            READ_NOT_WRITE <= 1'b1;
        end else if (rnw_flip) begin
            READ_NOT_WRITE <= read_r;
        end
    end

    // address strobe half a bus clock after the cycle begins, high again after the terminator
    always_ff @(posedge CLK) begin
        if (SRST) begin
            ADDRESS_STROBE_N <= 1'b1;
        end else if (cycle_start) begin
            ADDRESS_STROBE_N <= 1'b0;
        end else if (cycle_end) begin
            ADDRESS_STROBE_N <= 1'b1;
        end
    end

    // data strobe: with the address strobe on reads, one bus clock later on writes
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DATA_STROBE_N <= 1'b1;
        end else if (cycle_start) begin
            DATA_STROBE_N <= !read_r;
        end else if (ds_write) begin
            DATA_STROBE_N <= 1'b0;
        end else if (cycle_end) begin
            DATA_STROBE_N <= 1'b1;
        end
    end

    // write data on all sixteen lines half a bus clock after the address strobe
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DATA_OUT <= '0;
        end else if (oe_on) begin
            DATA_OUT <= wr_word;
        end
    end

    // lines driven from write data launch until the cycle has closed
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DATA_OE <= 1'b0;
        end else if (oe_on) begin
            DATA_OE <= 1'b1;
        end else if (oe_off) begin
            DATA_OE <= 1'b0;
        end
    end

    // completion pulse once the whole operand has moved or a terminator ended it
    always_ff @(posedge CLK) begin
        if (SRST) begin
            DONE <= 1'b0;
        end else begin
            DONE <= operand_end;
        end
    end

    // read result right-justified for the requester
    always_ff @(posedge CLK) begin
        if (SRST) begin
            RDATA <= 32'h00000000;
        end else if (operand_end && take_read) begin
            RDATA <= rdata_just;
        end
    end

    // bus fault ends the whole operand; with the stall line it is an exception
    always_ff @(posedge CLK) begin
        if (SRST) begin
            BUS_ERROR <= 1'b0;
            BUS_ERROR_EXC <= 1'b0;
        end else begin
            BUS_ERROR <= operand_end && fault_term;
            BUS_ERROR_EXC <= operand_end && fault_exc;
        end
    end

    // auto vector counts only on an interrupt-acknowledge cycle
    always_ff @(posedge CLK) begin
        if (SRST) begin
            AUTO_VECTOR <= 1'b0;
        end else begin
            AUTO_VECTOR <= operand_end && auto_vector_term_only;
        end
    end
endmodule : aebm_master

// file: aebm_master_sva.sv
// aebm_master_sva: pin timing checks for the external bus master
// assumes it is bound to aebm_master and sees only its ports
`timescale 1ns/1ps
module aebm_master_sva
    import aebm_pkg::*;
(
    // clock, reset and request
    input wire logic CLK,
    input wire logic SRST,
    input wire logic REQ_IACK,
    // internal answer
    input wire logic DONE,
    input wire logic BUS_ERROR,
    input wire logic BUS_ERROR_EXC,
    // bus outputs
    input wire logic [aebm_pkg::ADDR_W-1:0] ADDR,
    input wire logic TRANSFER_SIZE_HIGH,
    input wire logic TRANSFER_SIZE_LOW,
    input wire logic [2:0] SPACE_CODE,
    input wire logic READ_NOT_WRITE,
    input wire logic ADDRESS_STROBE_N,
    input wire logic DATA_STROBE_N,
    input wire logic DATA_OE,
    // terminators
    input wire logic PORT_SIZE_ACK_HIGH_N,
    input wire logic PORT_SIZE_ACK_LOW_N,
    input wire logic BUS_FAULT_N,
    input wire logic AUTO_VECTOR_TERM_N
);
    // short aliases and terminator decode
    wire as_n = ADDRESS_STROBE_N;
    wire ds_n = DATA_STROBE_N;
    wire rnw = READ_NOT_WRITE;
    wire [1:0] ack = {PORT_SIZE_ACK_HIGH_N, PORT_SIZE_ACK_LOW_N};
    wire stop = ack == ACK_PORT8 || ack == ACK_PORT16;
    wire idle_term = BUS_FAULT_N && (AUTO_VECTOR_TERM_N || !REQ_IACK);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SRST);
    a_read_ds_early: assert property ($fell(as_n) && rnw |-> !ds_n) else $error("read strobe late");
    a_write_ds_late: assert property ($fell(as_n) && !rnw |-> ds_n [*2] ##1 !ds_n) else $error("write ds");
    a_write_data_at: assert property ($fell(as_n) && !rnw |-> !DATA_OE ##1 DATA_OE) else $error("data drive");
    a_ctrl_held: assert property (!as_n && !$past(as_n) |-> $stable({ADDR, TRANSFER_SIZE_HIGH, TRANSFER_SIZE_LOW,
        SPACE_CODE, rnw})) else $error("control moved");
    a_strobe_gap: assert property ($rose(as_n) |-> (as_n && ds_n) [*2]) else $error("no gap");
    a_wait_holds: assert property (!as_n && !stop && idle_term |=> !as_n) else $error("ended early");
    a_ack_ends: assert property (!as_n && !ds_n && stop |-> ##[1:3] as_n) else $error("not ended");
    a_fault_done: assert property (BUS_ERROR |-> DONE) else $error("fault without done");
    a_exc_fault: assert property (BUS_ERROR_EXC |-> BUS_ERROR) else $error("exception without fault");
    a_rnw_start: assert property ($changed(rnw) |-> $fell(as_n)) else $error("direction moved");
endmodule : aebm_master_sva

bind aebm_master aebm_master_sva i_aebm_master_sva (.CLK(CLK), .SRST(SRST), .REQ_IACK(REQ_IACK), .DONE(DONE),
    .BUS_ERROR(BUS_ERROR), .BUS_ERROR_EXC(BUS_ERROR_EXC), .ADDR(ADDR), .TRANSFER_SIZE_HIGH(TRANSFER_SIZE_HIGH),
    .TRANSFER_SIZE_LOW(TRANSFER_SIZE_LOW), .SPACE_CODE(SPACE_CODE), .READ_NOT_WRITE(READ_NOT_WRITE),
    .ADDRESS_STROBE_N(ADDRESS_STROBE_N), .DATA_STROBE_N(DATA_STROBE_N), .DATA_OE(DATA_OE),
    .PORT_SIZE_ACK_HIGH_N(PORT_SIZE_ACK_HIGH_N), .PORT_SIZE_ACK_LOW_N(PORT_SIZE_ACK_LOW_N),
    .BUS_FAULT_N(BUS_FAULT_N), .AUTO_VECTOR_TERM_N(AUTO_VECTOR_TERM_N));

// file: aebm_pkg.sv
// aebm_pkg: constants shared by the external bus master, its checker, the slave model and the testbench
// assumes a single 200 MHz clock; no software-visible registers exist
package aebm_pkg;
    localparam int ADDR_W = 24;
    localparam int DATA_W = 16;
    // transfer size encodings {high, low}
    localparam logic [1:0] SIZE_BYTE = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [1:0] SIZE_THREE = 2'h3;
    localparam logic [1:0] SIZE_LONG = 2'h0;
    // space codes
    localparam logic [2:0] SPACE_USER_DATA = 3'h1;
    localparam logic [2:0] SPACE_USER_PROG = 3'h2;
    localparam logic [2:0] SPACE_SUPV_DATA = 3'h5;
    localparam logic [2:0] SPACE_SUPV_PROG = 3'h6;
    localparam logic [2:0] SPACE_CONTROL = 3'h7;
    // active-low acknowledge pairs {high, low}
    localparam logic [1:0] ACK_WAIT = 2'h3;
    localparam logic [1:0] ACK_PORT8 = 2'h2;
    localparam logic [1:0] ACK_PORT16 = 2'h1;
    localparam logic [1:0] ACK_RESVD = 2'h0;
    // operand byte counts
    localparam logic [2:0] BYTES_ONE = 3'h1;
    localparam logic [2:0] BYTES_TWO = 3'h2;
    localparam logic [2:0] BYTES_FOUR = 3'h4;
    // bus cycle states
    typedef enum logic [2:0] {
        AEBM_IDLE = 3'b000,
        AEBM_S0 = 3'b001,
        AEBM_S1 = 3'b010,
        AEBM_S2 = 3'b011,
        AEBM_WAIT = 3'b100,
        AEBM_END = 3'b101
    } aebm_state_e;
endpackage : aebm_pkg

// file: aebm_slave_model.sv
// aebm_slave_model: byte memory slave on the external bus, 8 or 16 bit wide
// assumes master outputs change on the rising clock; mode 0 ack, 1 fault, 2 auto vector
`timescale 1ns/1ps
module aebm_slave_model
    import aebm_pkg::*;
(
    // clock, reset and behaviour
    input wire logic clk,
    input wire logic srst,
    input wire logic port8,
    input wire logic [3:0] wait_n,
    input wire logic [1:0] mode,
    // master side
    input wire logic [23:0] addr,
    input wire logic [1:0] size,
    input wire logic rnw,
    input wire logic as_n,
    input wire logic ds_n,
    input wire logic [15:0] dout,
    // slave answers
    output logic [15:0] din,
    output logic [1:0] ack_n,
    output logic fault_n,
    output logic auto_vector_term_n
);
    logic [7:0] mem [256];
    logic [3:0] cnt;
    logic ans;
    logic [15:0] last;
    wire sel = !as_n && !ds_n;
    wire [7:0] a = addr[7:0];
    wire [7:0] ae = {a[7:1], 1'b0};
    // narrow port answers on the upper lane, the lower lane shows junk
    wire [15:0] rd = port8 ? {mem[a], ~mem[a]} : {mem[ae], mem[ae | 8'h01]};
    assign din = (sel && rnw) ? rd : ~last;
    // in mode 0 a 16-bit slave always answers the 16-bit code
    assign ack_n = (ans && mode == 2'h0) ? (port8 ? ACK_PORT8 : ACK_PORT16) : ACK_WAIT;
    assign fault_n = !(ans && mode == 2'h1);
    assign auto_vector_term_n = !(ans && mode == 2'h2);
    // wait states, then store writes before answering
    always @(posedge clk) begin
        if (sel && rnw) last <= rd;
        if (srst || as_n) begin
            cnt <= 4'h0;
            ans <= 1'b0;
        end else if (sel && !ans) begin
            cnt <= cnt + 4'h1;
            if (cnt >= wait_n) begin
                ans <= 1'b1;
                if (!rnw && port8) mem[a] <= dout[15:8];
                if (!rnw && !port8 && size == SIZE_BYTE) mem[a] <= a[0] ? dout[7:0] : dout[15:8];
                if (!rnw && !port8 && size != SIZE_BYTE) {mem[ae], mem[ae | 8'h01]} <= dout;
            end
        end
    end
endmodule : aebm_slave_model

// file: test_async_external_bus_master.sv
// test_async_external_bus_master: table driven transfers plus fault and vector cases
// assumes inputs change at the falling edge and the slave model answers the bus
`timescale 1ns/1ps
module test_async_external_bus_master;
    import aebm_pkg::*;
    typedef struct packed {logic rd; logic [2:0] nb; logic [23:0] a; logic [31:0] d;
        logic p8; logic [3:0] wt; logic [7:0] sz; logic [2:0] nc;} aebm_row_s;
    localparam aebm_row_s ROWS [9] = '{'{0, 4, 24'h10, 32'h11223344, 0, 1, 8'h20, 2},
        '{1, 4, 24'h10, 32'h11223344, 0, 3, 8'h20, 2}, '{0, 2, 24'h20, 32'ha5c3, 1, 1, 8'h90, 2},
        '{1, 2, 24'h20, 32'ha5c3, 1, 0, 8'h90, 2}, '{0, 1, 24'h31, 32'h7e, 0, 2, 8'h40, 1},
        '{0, 4, 24'h40, 32'hdeadbeef, 1, 0, 8'h39, 4}, '{1, 1, 24'h31, 32'h7e, 0, 0, 8'h40, 1},
        '{1, 4, 24'h40, 32'hdeadbeef, 0, 1, 8'h20, 2}, '{1, 4, 24'h10, 32'h11223344, 1, 0, 8'h39, 4}};
    localparam logic [2:0] SPC [5] = '{SPACE_USER_DATA, SPACE_USER_PROG, SPACE_SUPV_DATA, SPACE_SUPV_PROG,
        SPACE_CONTROL};
    logic clk = 0, srst = 1, req_valid = 0, req_iack = 0, stall_n = 1, as_q = 1, done_seen;
    logic done, be, exc, av, rnw, as_n, ds_n, oe, sh, sl, fault_n, auto_vector_term_n;
    logic [1:0] ack_n, mode = 0;
    logic [2:0] spc = 0, space;
    logic [23:0] addr;
    logic [15:0] din, dout;
    logic [31:0] rdata, rd;
    aebm_row_s cur = ROWS[0];
    int err_total = 0, n_compared = 0, ncyc = 0, tick = 0;
    always #2.5 clk = ~clk;
    aebm_master i_aebm_master (.CLK(clk), .SRST(srst), .REQ_VALID(req_valid), .REQ_READ(cur.rd),
        .REQ_BYTES(cur.nb), .REQ_ADDR(cur.a), .REQ_SPACE(spc), .REQ_IACK(req_iack), .REQ_WDATA(cur.d), .DONE(done),
        .RDATA(rdata), .BUS_ERROR(be), .BUS_ERROR_EXC(exc), .AUTO_VECTOR(av), .ADDR(addr), .TRANSFER_SIZE_HIGH(sh),
        .TRANSFER_SIZE_LOW(sl), .SPACE_CODE(space), .READ_NOT_WRITE(rnw), .ADDRESS_STROBE_N(as_n),
        .DATA_STROBE_N(ds_n), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe), .PORT_SIZE_ACK_HIGH_N(ack_n[1]),
        .PORT_SIZE_ACK_LOW_N(ack_n[0]), .BUS_FAULT_N(fault_n), .STALL_LINE_N(stall_n), .AUTO_VECTOR_TERM_N(auto_vector_term_n));
    aebm_slave_model i_aebm_slave_model (.clk(clk), .srst(srst), .port8(cur.p8), .wait_n(cur.wt), .mode(mode),
        .addr(addr), .size({sh, sl}), .rnw(rnw), .as_n(as_n), .ds_n(ds_n), .dout(dout), .din(din), .ack_n(ack_n),
        .fault_n(fault_n), .auto_vector_term_n(auto_vector_term_n));
    task summarize;
        if (err_total == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : summarize
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk
    task op(input int lim);
        @(negedge clk) req_valid = 1;
        ncyc = 0;
        done_seen = 0;
        for (int k = 0; k < lim && !done_seen; k++) @(negedge clk) done_seen = (done === 1'b1);
        rd = rdata;
        req_valid = 0;
    endtask : op
    // each bus cycle start in mode 0: space, size and address of the bytes still to move
    always @(negedge clk) begin
        if (as_q && !as_n && mode == 0 && ncyc < 4) begin
            chk("space", spc, space);
            chk("dir", cur.rd, rnw);
            chk("size", cur.sz[7 - 2 * ncyc -: 2], {sh, sl});
            chk("addr", cur.a + ncyc * (cur.p8 ? 1 : 2), addr);
        end
        if (as_q && !as_n) ncyc++;
        as_q = as_n;
        if (++tick > 20000) begin
            err_total++;
            summarize();
        end
    end
    initial begin
        repeat (10) @(negedge clk);
        chk("reset pins", 32'h1d, {addr == 0, as_n, ds_n, oe, rnw});
        srst = 0;
        for (int i = 0; i < 9; i++) begin
            cur = ROWS[i];
            spc = SPC[i % 5];
            op(100);
            chk("cycles", cur.nc, ncyc);
            chk("done", 1, done_seen);
            if (cur.rd) chk("rdata", cur.d, rd);
        end
        mode = 1;
        for (int s = 0; s < 2; s++) begin
            stall_n = s[0];
            op(100);
            chk("fault", {1'b1, !s[0]}, {be, exc});
        end
        {mode, req_iack, spc} = {2'h2, 1'b1, SPACE_CONTROL};
        op(100);
        chk("vector", 2'h3, {done_seen, av});
        req_iack = 0;
        op(40);
        chk("vector ignored", 0, done_seen);
        srst = 1;
        repeat (3) @(negedge clk);
        srst = 0;
        chk("strobes after reset", 2'h3, {as_n, ds_n});
        summarize();
    end
endmodule : test_async_external_bus_master
